// >>> verilog/lsr_map.vh
`ifndef LSR_MAP_VH
`define LSR_MAP_VH

// Register byte addresses
`define LSR_ADDR_DIODE1_IDEAL 8'h27
`define LSR_ADDR_DIODE2_IDEAL 8'h28
`define LSR_ADDR_DIODE3_IDEAL 8'h31
`define LSR_ADDR_UPPER_FLAGS 8'h35
`define LSR_ADDR_LOWER_FLAGS 8'h36
`define LSR_ADDR_SEVERE_FLAGS 8'h37

// Ideality register layout
`define LSR_IDEAL_RESET 8'h12
`define LSR_IDEAL_SEL_RESET 3'h2
`define LSR_IDEAL_FIXED 5'h02
`define LSR_IDEAL_SEL_MSB 2
`define LSR_IDEAL_SEL_LSB 0

// Status register layout: bits 7,6,3..0 live, bits 5,4 unused
`define LSR_FLAGS_RESET 8'h00
`define LSR_FLAGS_VALID 8'hCF
`define LSR_BIT_SENSE_VOLT 7
`define LSR_BIT_SOURCE_VOLT 6
`define LSR_BIT_DIODE3 3
`define LSR_BIT_DIODE2 2
`define LSR_BIT_DIODE1 1
`define LSR_BIT_INTERNAL 0

// Ideality factor times ten thousand, for settings 10h..17h
`define LSR_FACTOR_0 16'h2745
`define LSR_FACTOR_1 16'h2752
`define LSR_FACTOR_2 16'h2760
`define LSR_FACTOR_3 16'h276D
`define LSR_FACTOR_4 16'h277A
`define LSR_FACTOR_5 16'h2787
`define LSR_FACTOR_6 16'h2795
`define LSR_FACTOR_7 16'h27A2

// Serial bus defaults
`define LSR_SMB_ADDR_DEFAULT 7'h2A
`define LSR_UNMAPPED_READ 8'h00

`endif

// >>> verilog/lsr_pin_sync.v
`default_nettype none

module lsr_pin_sync (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_b_i,
  // Pin in, filtered level out
  input wire pin_i,
  output wire level_o
);

  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg level_q;

  // Idle bus level is high, so reset to one
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level_q <= 1'b1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  assign level_o = level_q;

endmodule

`default_nettype wire

// >>> verilog/lsr_limit_regs.v
`include "lsr_map.vh"
`default_nettype none

// Behaviour
// - Three ideality registers, fixed 010, 3-bit select
// - Settings 10h-17h map to ascending factors
// - Upper flags set when reading at/above limit
// - Any upper flag sets upper summary bit
// - Read clears upper flags whose condition ended
// - Unmasked flag plus met queue asserts alert
// - Upper flags latch, or follow in comparator
// - Lower flags set when reading below limit
// - Any lower flag sets lower summary bit
// - Read clears lower flags; summary if gone
// - Lower flags stay latched until read
// - Severe flags set at limit, set summary
// - Reading severe flags has no side effect
// - Severe flag self-clears below limit minus hysteresis
// - Severe summary clears when all flags clear
// - Any severe flag drives severe pin low
// - Channel block bit keeps it off alert
// - Comparator mode counts only upper limit hits
module lsr_limit_regs #(
  parameter [6:0] SMB_ADDR = `LSR_SMB_ADDR_DEFAULT
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_b_i,
  // Serial bus pins, open drain data
  input wire smclk_i,
  input wire smdata_i,
  output wire smdata_o,
  output wire smdata_oe_o,
  // Conversion results from the comparison datapath
  input wire conv_valid_i,
  input wire [7:0] over_upper_i,
  input wire [7:0] under_lower_i,
  input wire [7:0] at_severe_i,
  input wire [7:0] below_severe_hyst_i,
  input wire [7:0] queue_met_i,
  // Alert configuration
  input wire alert_comparator_i,
  input wire [7:0] alert_block_i,
  // Main status summary bits
  output wire upper_summary_o,
  output wire lower_summary_o,
  output wire severe_summary_o,
  // Open drain output pins, active low
  output wire alert_n_o,
  output wire alert_n_oe_o,
  output wire severe_out_pin_o,
  output wire severe_out_pin_oe_o,
  // Ideality settings for the conversion engine
  output wire [2:0] diode1_factor_sel_o,
  output wire [2:0] diode2_factor_sel_o,
  output wire [2:0] diode3_factor_sel_o,
  output wire [15:0] diode1_factor_o,
  output wire [15:0] diode2_factor_o,
  output wire [15:0] diode3_factor_o
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_ACK_WAIT = 3'h2;
  localparam [2:0] S_ACK = 3'h3;
  localparam [2:0] S_RX = 3'h4;
  localparam [2:0] S_TX = 3'h5;
  localparam [2:0] S_MACK = 3'h6;

  wire [7:0] valid_mask = `LSR_FLAGS_VALID;

  // Reset release through two flops
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_b = rst_s2_q;

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Bus pin conditioning
  wire scl_s;
  wire sda_s;

  lsr_pin_sync u_scl_sync (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b),
    .pin_i(smclk_i),
    .level_o(scl_s)
  );

  lsr_pin_sync u_sda_sync (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b),
    .pin_i(smdata_i),
    .level_o(sda_s)
  );

  reg scl_p_q;
  reg sda_p_q;
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Bus slave state
  reg [2:0] state_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] ptr_q;
  reg rw_q;
  reg got_cmd_q;
  reg drive_q;

  wire [7:0] rx_byte = {sh_q[6:0], sda_s};
  wire byte_end = scl_rise & (bit_q == 3'h7);
  wire addr_hit = (sh_q[6:0] == SMB_ADDR);
  wire rd_first = (state_q == S_ADDR) & byte_end & addr_hit & sda_s;
  wire rd_next = (state_q == S_MACK) & scl_rise & ~sda_s;
  wire rd_en = rd_first | rd_next;
  wire wr_en = (state_q == S_RX) & byte_end & got_cmd_q;

  // Register storage
  reg [7:0] upper_q;
  reg [7:0] lower_q;
  reg [7:0] severe_q;
  reg upper_sum_q;
  reg lower_sum_q;
  reg severe_sum_q;
  reg alert_q;
  wire [8:0] sel_all;
  wire [47:0] factor_all;

  // Read side effects only for the two clear-on-read registers
  wire rd_upper = rd_en & (ptr_q == `LSR_ADDR_UPPER_FLAGS);
  wire rd_lower = rd_en & (ptr_q == `LSR_ADDR_LOWER_FLAGS);

  function [15:0] factor_of;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: factor_of = `LSR_FACTOR_0;
        3'h1: factor_of = `LSR_FACTOR_1;
        3'h2: factor_of = `LSR_FACTOR_2;
        3'h3: factor_of = `LSR_FACTOR_3;
        3'h4: factor_of = `LSR_FACTOR_4;
        3'h5: factor_of = `LSR_FACTOR_5;
        3'h6: factor_of = `LSR_FACTOR_6;
        default: factor_of = `LSR_FACTOR_7;
      endcase
    end
  endfunction

  // Per-diode ideality select and decoded factor
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ideal
      localparam [7:0] REG_ADDR = (gi == 0) ? `LSR_ADDR_DIODE1_IDEAL :
                                  (gi == 1) ? `LSR_ADDR_DIODE2_IDEAL :
                                  `LSR_ADDR_DIODE3_IDEAL;
      reg [2:0] sel_q;
      reg [15:0] factor_q;
      always @(posedge core_clk_i or negedge rst_b) begin
        if (!rst_b) begin
          sel_q <= `LSR_IDEAL_SEL_RESET;
          factor_q <= `LSR_FACTOR_2;
        end else begin
          if (wr_en && (ptr_q == REG_ADDR)) begin
            sel_q <= rx_byte[`LSR_IDEAL_SEL_MSB:`LSR_IDEAL_SEL_LSB];
          end
          factor_q <= factor_of(sel_q);
        end
      end
      assign sel_all[gi*3 +: 3] = sel_q;
      assign factor_all[gi*16 +: 16] = factor_q;
    end
  endgenerate

  assign diode1_factor_sel_o = sel_all[2:0];
  assign diode2_factor_sel_o = sel_all[5:3];
  assign diode3_factor_sel_o = sel_all[8:6];
  assign diode1_factor_o = factor_all[15:0];
  assign diode2_factor_o = factor_all[31:16];
  assign diode3_factor_o = factor_all[47:32];

  // Limit flag events, qualified by a finished conversion
  wire [7:0] upper_evt = {8{conv_valid_i}} & over_upper_i & valid_mask;
  wire [7:0] lower_evt = {8{conv_valid_i}} & under_lower_i & valid_mask;
  wire [7:0] severe_evt = {8{conv_valid_i}} & at_severe_i & valid_mask;
  wire [7:0] severe_rel = {8{conv_valid_i}} & below_severe_hyst_i & ~at_severe_i;

  reg [7:0] upper_d;
  reg [7:0] lower_d;
  reg [7:0] severe_d;
  reg lower_sum_d;

  always @* begin
    if (alert_comparator_i) begin
      upper_d = over_upper_i & valid_mask;
    end else if (rd_upper) begin
      upper_d = over_upper_i & upper_q & valid_mask | upper_evt;
    end else begin
      upper_d = upper_q | upper_evt;
    end
    if (rd_lower) begin
      lower_d = lower_evt;
    end else begin
      lower_d = lower_q | lower_evt;
    end
    // Severe flags ignore reads entirely
    severe_d = (severe_q & ~severe_rel) | severe_evt;
    lower_sum_d = lower_sum_q;
    if (rd_lower && ((under_lower_i & valid_mask) == 8'h00)) begin
      lower_sum_d = 1'b0;
    end
    if (lower_d != 8'h00) begin
      lower_sum_d = 1'b1;
    end
  end

  // Comparator mode drops lower flags from the alert path
  wire [7:0] alert_src = alert_comparator_i ? upper_q : (upper_q | lower_q);
  wire alert_d = |(alert_src & ~alert_block_i & queue_met_i);

  always @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      upper_q <= `LSR_FLAGS_RESET;
      lower_q <= `LSR_FLAGS_RESET;
      severe_q <= `LSR_FLAGS_RESET;
      upper_sum_q <= 1'b0;
      lower_sum_q <= 1'b0;
      severe_sum_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      upper_q <= upper_d;
      lower_q <= lower_d;
      severe_q <= severe_d;
      upper_sum_q <= |upper_d;
      lower_sum_q <= lower_sum_d;
      severe_sum_q <= |severe_d;
      alert_q <= alert_d;
    end
  end

  assign upper_summary_o = upper_sum_q;
  assign lower_summary_o = lower_sum_q;
  assign severe_summary_o = severe_sum_q;
  assign alert_n_o = 1'b0;
  assign alert_n_oe_o = alert_q;
  assign severe_out_pin_o = 1'b0;
  assign severe_out_pin_oe_o = severe_sum_q;

  // Read data mux
  reg [7:0] rd_data;
  always @* begin
    case (ptr_q)
      // Fixed field spans bits 7..3, so bits 7:6 read zero
      `LSR_ADDR_DIODE1_IDEAL: rd_data = {`LSR_IDEAL_FIXED, sel_all[2:0]};
      `LSR_ADDR_DIODE2_IDEAL: rd_data = {`LSR_IDEAL_FIXED, sel_all[5:3]};
      `LSR_ADDR_DIODE3_IDEAL: rd_data = {`LSR_IDEAL_FIXED, sel_all[8:6]};
      `LSR_ADDR_UPPER_FLAGS: rd_data = upper_q & valid_mask;
      `LSR_ADDR_LOWER_FLAGS: rd_data = lower_q & valid_mask;
      `LSR_ADDR_SEVERE_FLAGS: rd_data = severe_q & valid_mask;
      default: rd_data = `LSR_UNMAPPED_READ;
    endcase
  end

  // Byte-level slave: sample on clock rise, drive data after clock fall
  always @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      state_q <= S_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      got_cmd_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      if (bus_stop) begin
        state_q <= S_IDLE;
        drive_q <= 1'b0;
      end else if (bus_start) begin
        // Repeated start keeps the pointer for read-after-command
        state_q <= S_ADDR;
        bit_q <= 3'h0;
        got_cmd_q <= 1'b0;
        drive_q <= 1'b0;
      end else begin
        case (state_q)
          S_IDLE: begin
            drive_q <= 1'b0;
          end
          S_ADDR: begin
            if (scl_rise) begin
              sh_q <= rx_byte;
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                if (addr_hit) begin
                  rw_q <= sda_s;
                  state_q <= S_ACK_WAIT;
                  if (sda_s) begin
                    sh_q <= rd_data;
                    ptr_q <= ptr_q + 8'h01;
                  end
                end else begin
                  state_q <= S_IDLE;
                end
              end
            end
          end
          S_ACK_WAIT: begin
            if (scl_fall) begin
              drive_q <= 1'b1;
              state_q <= S_ACK;
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bit_q <= 3'h0;
              if (rw_q) begin
                drive_q <= ~sh_q[7];
                state_q <= S_TX;
              end else begin
                drive_q <= 1'b0;
                state_q <= S_RX;
              end
            end
          end
          S_RX: begin
            if (scl_rise) begin
              sh_q <= rx_byte;
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                state_q <= S_ACK_WAIT;
                if (got_cmd_q) begin
                  ptr_q <= ptr_q + 8'h01;
                end else begin
                  ptr_q <= rx_byte;
                  got_cmd_q <= 1'b1;
                end
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bit_q == 3'h7) begin
                drive_q <= 1'b0;
                state_q <= S_MACK;
              end else begin
                drive_q <= ~sh_q[6];
                sh_q <= {sh_q[6:0], 1'b0};
                bit_q <= bit_q + 3'h1;
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              if (!sda_s) begin
                sh_q <= rd_data;
                ptr_q <= ptr_q + 8'h01;
                state_q <= S_ACK;
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
          default: begin
            state_q <= S_IDLE;
            drive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign smdata_o = 1'b0;
  assign smdata_oe_o = drive_q;

endmodule

`default_nettype wire

// >>> sim/lsr_limit_props.sv
`default_nettype none
module lsr_limit_props (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Inputs
  input wire logic conv_valid_i,
  input wire logic alert_comparator_i,
  input wire logic [7:0] over_upper_i,
  input wire logic [7:0] under_lower_i,
  input wire logic [7:0] at_severe_i,
  input wire logic [7:0] queue_met_i,
  input wire logic [7:0] alert_block_i,
  // Outputs
  input wire logic alert_n_oe_o,
  input wire logic severe_out_pin_oe_o,
  input wire logic upper_summary_o,
  input wire logic lower_summary_o,
  input wire logic severe_summary_o,
  input wire logic [2:0] diode1_factor_sel_o,
  input wire logic [15:0] diode1_factor_o
);
  // Bits 5 and 4 carry no channel
  localparam logic [7:0] LIVE = 8'hCF;
  localparam logic [15:0] FT [8] = '{16'h2745, 16'h2752, 16'h2760, 16'h276D,
    16'h277A, 16'h2787, 16'h2795, 16'h27A2};
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_sev_evt;
    conv_valid_i && (at_severe_i & LIVE) != 8'h00;
  endsequence
  sequence s_comp_quiet;
    (alert_comparator_i && (over_upper_i & LIVE) == 8'h00) [*3];
  endsequence
  a_severe_pin_tie: assert property ((severe_out_pin_oe_o == severe_summary_o) and
    (s_sev_evt |=> severe_out_pin_oe_o)) else $error("severe pin differs from summary");
  a_severe_set: assert property (s_sev_evt |-> ##[1:2] severe_summary_o)
    else $error("severe summary not set");
  a_severe_self_clear: assert property ($fell(severe_summary_o) |->
    $past(conv_valid_i) || $past(conv_valid_i, 2)) else $error("severe fell alone");
  a_upper_set: assert property (conv_valid_i && !alert_comparator_i &&
    (over_upper_i & LIVE) != 8'h00 |-> ##[1:2] upper_summary_o) else $error("upper not set");
  a_lower_set: assert property (conv_valid_i && (under_lower_i & LIVE) != 8'h00 |->
    ##[1:2] lower_summary_o) else $error("lower not set");
  a_comp_follow: assert property (s_comp_quiet |-> !upper_summary_o)
    else $error("upper held in comparator mode");
  a_alert_blocked: assert property ($past(alert_block_i) == 8'hFF |-> !alert_n_oe_o)
    else $error("alert while all blocked");
  a_alert_queue: assert property ($past(queue_met_i) == 8'h00 |-> !alert_n_oe_o)
    else $error("alert before queue met");
  a_factor_map: assert property (diode1_factor_o == FT[$past(diode1_factor_sel_o)])
    else $error("ideality factor wrong");
endmodule
bind lsr_limit_regs lsr_limit_props u_props (.core_clk_i, .rst_b_i, .conv_valid_i,
  .alert_comparator_i, .over_upper_i, .under_lower_i, .at_severe_i, .queue_met_i,
  .alert_block_i, .alert_n_oe_o, .severe_out_pin_oe_o, .upper_summary_o, .lower_summary_o,
  .severe_summary_o, .diode1_factor_sel_o, .diode1_factor_o);
`default_nettype wire

// >>> sim/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i = 1'h0, rst_b_i = 1'h0, smclk_i = 1'h1, sda_lo = 1'h0;
  logic conv_valid_i = 1'h0, alert_comparator_i = 1'h0;
  logic [7:0] over_upper_i = 8'h00, under_lower_i = 8'h00, at_severe_i = 8'h00;
  logic [7:0] below_severe_hyst_i = 8'h00, queue_met_i = 8'hFF, alert_block_i = 8'h00;
  wire logic smdata_o, smdata_oe_o, alert_n_o, alert_n_oe_o, severe_out_pin_o;
  wire logic severe_out_pin_oe_o, upper_summary_o, lower_summary_o, severe_summary_o;
  wire logic [2:0] diode1_factor_sel_o, diode2_factor_sel_o, diode3_factor_sel_o;
  wire logic [15:0] diode1_factor_o, diode2_factor_o, diode3_factor_o;
  // Pulled up, low while either side pulls
  wire logic sda = !(sda_lo || smdata_oe_o);
  int error_cnt = 0;
  int checks = 0;
  always #2 core_clk_i = ~core_clk_i;
  lsr_limit_regs DUT (.core_clk_i, .rst_b_i, .smclk_i, .smdata_i(sda), .smdata_o,
    .smdata_oe_o, .conv_valid_i, .over_upper_i, .under_lower_i, .at_severe_i,
    .below_severe_hyst_i, .queue_met_i, .alert_comparator_i, .alert_block_i,
    .upper_summary_o, .lower_summary_o, .severe_summary_o, .alert_n_o, .alert_n_oe_o,
    .severe_out_pin_o, .severe_out_pin_oe_o, .diode1_factor_sel_o, .diode2_factor_sel_o,
    .diode3_factor_sel_o, .diode1_factor_o, .diode2_factor_o, .diode3_factor_o);
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Ten clocks per phase, the filter needs four
  task automatic ph(input logic c, input logic d);
    smclk_i = c;
    sda_lo = d;
    tick(10);
  endtask
  task automatic bt(input logic b, output logic r);
    ph(1'h0, !b);
    ph(1'h1, !b);
    r = sda;
    ph(1'h0, !b);
  endtask
  task automatic tx(input logic [7:0] d, input logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'h1, r);
    chk(r, a);
  endtask
  task automatic st;
    ph(1'h0, 1'h0);
    ph(1'h1, 1'h0);
    ph(1'h1, 1'h1);
    ph(1'h0, 1'h1);
  endtask
  task automatic sp;
    ph(1'h0, 1'h1);
    ph(1'h1, 1'h1);
    ph(1'h1, 1'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic r;
    st;
    tx(8'h54, 1'h0);
    tx(a, 1'h0);
    st;
    tx(8'h55, 1'h0);
    for (int i = 7; i >= 0; i--) bt(1'h1, d[i]);
    bt(1'h1, r);
    sp;
    chk(d, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    st;
    tx(8'h54, 1'h0);
    tx(a, 1'h0);
    tx(d, 1'h0);
    sp;
  endtask
  task automatic cv;
    conv_valid_i = 1'h1;
    tick(1);
    conv_valid_i = 1'h0;
    tick(3);
  endtask
  task automatic t_reset;
    logic [7:0] ad [6] = '{8'h27, 8'h28, 8'h31, 8'h35, 8'h36, 8'h37};
    chk({upper_summary_o, lower_summary_o, severe_summary_o, alert_n_oe_o}, 16'h0000);
    chk({diode1_factor_sel_o, diode2_factor_sel_o, diode3_factor_sel_o}, 16'h0092);
    chk(diode1_factor_o, 16'h2760);
    chk({smdata_o, alert_n_o, severe_out_pin_o}, 16'h0000);
    for (int i = 0; i < 6; i++) rd(ad[i], i < 3 ? 8'h12 : 8'h00);
    rd(8'h50, 8'h00);
    st;
    tx(8'h56, 1'h1);
    sp;
    $display("t_reset end");
  endtask
  task automatic t_ideal;
    logic [15:0] ft [8] = '{16'h2745, 16'h2752, 16'h2760, 16'h276D,
      16'h277A, 16'h2787, 16'h2795, 16'h27A2};
    for (int k = 0; k < 8; k++) begin
      wr(8'h27, 8'h10 + 8'(k));
      rd(8'h27, 8'h10 + 8'(k));
      chk(diode1_factor_sel_o, 16'(k));
      chk(diode1_factor_o, ft[k]);
    end
    wr(8'h28, 8'hFF);
    rd(8'h28, 8'h17);
    wr(8'h31, 8'h15);
    rd(8'h31, 8'h15);
    chk({diode2_factor_sel_o, diode3_factor_sel_o}, 16'h003D);
    chk(diode2_factor_o, ft[7]);
    chk(diode3_factor_o, ft[5]);
    wr(8'h27, 8'h12);
    $display("t_ideal end");
  endtask
  task automatic t_upper;
    over_upper_i = 8'hF2;
    cv;
    chk({upper_summary_o, alert_n_oe_o}, 16'h0003);
    over_upper_i = 8'h02;
    rd(8'h35, 8'hC2);
    wr(8'h35, 8'hFF);
    over_upper_i = 8'h00;
    rd(8'h35, 8'h02);
    rd(8'h35, 8'h00);
    chk({upper_summary_o, alert_n_oe_o}, 16'h0000);
    over_upper_i = 8'h02;
    alert_block_i = 8'h02;
    cv;
    chk({upper_summary_o, alert_n_oe_o}, 16'h0002);
    alert_block_i = 8'h00;
    tick(2);
    chk(alert_n_oe_o, 16'h0001);
    queue_met_i = 8'h00;
    tick(2);
    chk(alert_n_oe_o, 16'h0000);
    queue_met_i = 8'hFF;
    over_upper_i = 8'h00;
    rd(8'h35, 8'h02);
    $display("t_upper end");
  endtask
  task automatic t_lower;
    under_lower_i = 8'h71;
    cv;
    under_lower_i = 8'h00;
    cv;
    chk({lower_summary_o, alert_n_oe_o}, 16'h0003);
    under_lower_i = 8'h40;
    rd(8'h36, 8'h41);
    chk(lower_summary_o, 16'h0001);
    rd(8'h36, 8'h00);
    under_lower_i = 8'h00;
    rd(8'h36, 8'h00);
    chk(lower_summary_o, 16'h0000);
    $display("t_lower end");
  endtask
  task automatic t_severe;
    alert_block_i = 8'hFF;
    at_severe_i = 8'h09;
    cv;
    chk({severe_summary_o, severe_out_pin_oe_o}, 16'h0003);
    rd(8'h37, 8'h09);
    rd(8'h37, 8'h09);
    at_severe_i = 8'h00;
    below_severe_hyst_i = 8'h08;
    cv;
    rd(8'h37, 8'h01);
    chk(severe_summary_o, 16'h0001);
    below_severe_hyst_i = 8'h01;
    cv;
    chk({severe_summary_o, severe_out_pin_oe_o}, 16'h0000);
    rd(8'h37, 8'h00);
    below_severe_hyst_i = 8'h00;
    alert_block_i = 8'h00;
    $display("t_severe end");
  endtask
  task automatic t_comp;
    alert_comparator_i = 1'h1;
    over_upper_i = 8'h04;
    tick(4);
    chk({upper_summary_o, alert_n_oe_o}, 16'h0003);
    over_upper_i = 8'h00;
    tick(4);
    chk({upper_summary_o, alert_n_oe_o}, 16'h0000);
    under_lower_i = 8'h08;
    cv;
    under_lower_i = 8'h00;
    chk({lower_summary_o, alert_n_oe_o}, 16'h0002);
    rd(8'h36, 8'h08);
    alert_comparator_i = 1'h0;
    $display("t_comp end");
  endtask
  task automatic close_out;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    tick(16);
    rst_b_i = 1'h1;
    tick(6);
    t_reset;
    t_ideal;
    t_upper;
    t_lower;
    t_severe;
    t_comp;
    close_out;
  end
  // Cuts a hang short
  initial begin
    #380000;
    error_cnt++;
    close_out;
  end
endmodule
`default_nettype wire
